// [design/hsf_core.sv]
// Purpose: fault supervision, alert and gate policy of a hot-swap controller
// Assumes: pins arrive asynchronous; serial engine gives pulses on sys_clk_i
// Notes: registers reached over Avalon-MM, one wait state per access
`timescale 1ns/1ps
`default_nettype none
`include "hsf_defs.svh"

module hsf_core
  import hsf_pkg::*;
#(
  parameter int TD_CYC = (`HSF_CLK_HZ / 1000) * `HSF_TD_MS,
  parameter int CB_CYC = (`HSF_CLK_HZ / 1000000) * `HSF_CB_US,
  parameter int ADC_CYC = (`HSF_CLK_HZ * 10) / `HSF_ADC_DHZ / 3
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire hsf_pins_t pins_i,
  input wire logic [9:0] adc_data_i,
  input wire logic adc_done_i,
  output logic [1:0] adc_chan_o,
  output logic adc_start_o,
  input wire logic ara_release_i,
  input wire logic addressed_i,
  output logic gate_on_o,
  output logic power_good_output_n_o,
  output logic dual_purpose_power_good_pin_o,
  output logic dual_purpose_power_good_pin_oe_o,
  output logic alert_n_o,
  output logic alert_oe_o
);

  // ****************************************
  // constants
  // ****************************************
  localparam logic [9:0] SHORT_CODE =
    10'((`HSF_SHORT_UV * 1000) / `HSF_SENSE_LSB_NV);
  localparam logic [23:0] TD1 = 24'(TD_CYC - 1);
  localparam logic [23:0] TD4 = 24'(4 * TD_CYC - 1);
  localparam logic [23:0] CB1 = 24'(CB_CYC - 1);
  localparam logic [23:0] AD1 = 24'(ADC_CYC - 1);

  // ****************************************
  // pin synchroniser and edges
  // ****************************************
  hsf_pins_t pin_m;
  hsf_pins_t pin_s;
  hsf_pins_t pin_d;

  // two flops before use, third only for edges
  // reset to idle levels so no false edge or fault follows reset
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_m <= `HSF_PIN_IDLE;
      pin_s <= `HSF_PIN_IDLE;
      pin_d <= `HSF_PIN_IDLE;
    end else begin
      pin_m <= pins_i;
      pin_s <= pin_m;
      pin_d <= pin_s;
    end
  end

  logic [7:0] fault;
  logic [7:0] alert_en;
  logic [7:0] ctrl;
  logic [7:0] acked;
  logic [7:0] adc_q [0:5];
  logic host_d;
  logic ov_skip;
  logic oc_cool;
  logic uv_p;
  logic oc_p;
  logic pb_p;
  logic fs_p;
  logic chk_done;
  logic ack_q;
  logic alert_q;
  logic pg_q;
  logic [23:0] tmr;
  logic [23:0] cbt;
  logic [23:0] adt;
  hsf_gate_t state;

  wire on_rise = pin_s.on_pin & ~pin_d.on_pin;
  wire on_fall = pin_d.on_pin & ~pin_s.on_pin;
  wire ins_chg = pin_s.ins_det_n ^ pin_d.ins_det_n;
  wire ins_fall = pin_d.ins_det_n & ~pin_s.ins_det_n;
  wire uvl_rst = ~pin_s.uvl_above_rst;
  wire uvl_ret = pin_s.uvl_above_rst & ~pin_d.uvl_above_rst;
  wire host_fall = host_d & ~ctrl[`HSF_C_HOST];

  // ****************************************
  // register bus
  // ****************************************
  // the first cycle of a request waits, the second answers
  wire req = avs_read_i | avs_write_i;
  wire take = req & ~ack_q;
  wire wr_en = avs_write_i & ack_q;
  wire [3:0] idx = avs_address_i[5:2];
  wire [7:0] wd = avs_writedata_i[7:0];
  wire wr_fault = wr_en & (idx == `HSF_IDX_FAULT);
  wire wr_alert = wr_en & (idx == `HSF_IDX_ALERT);
  wire wr_ctrl = wr_en & (idx == `HSF_IDX_CTRL);
  wire frz = ctrl[`HSF_C_FRZ];
  wire adc_hit = (idx >= `HSF_IDX_ADC0) & (idx <= `HSF_IDX_ADC5);
  wire [2:0] adc_i = 3'(idx - `HSF_IDX_ADC0);
  wire wr_adc = wr_en & adc_hit & frz;

  assign avs_waitrequest_o = take;

  // status word: present bits, insertion level, gate
  wire gpi_p = (ctrl[7:6] == 2'b11) & pin_s.dual_purpose_power_good_pin_in;
  wire [7:0] status = {state == HSF_ON, gpi_p, fs_p,
    pin_s.ins_det_n, pb_p, oc_p, uv_p, pin_s.ov_trip};

  // read selection, unmapped words read as zero
  wire [7:0] rd_mux =
    (idx == `HSF_IDX_STATUS) ? status :
    (idx == `HSF_IDX_FAULT) ? fault :
    (idx == `HSF_IDX_ALERT) ? alert_en :
    (idx == `HSF_IDX_CTRL) ? ctrl :
    adc_hit ? adc_q[adc_i] : 8'h00;

  // read data captured one cycle ahead of the answer
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack_q <= take;
      if (take) begin
        avs_readdata_o <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ****************************************
  // present conditions
  // ****************************************
  wire ov_p = pin_s.ov_trip;
  wire pg_on = (state == HSF_ON) & pin_s.pg_ready;
  wire oc_trip = (state == HSF_ON) & pin_s.oc_limit
    & (cbt == CB1);
  wire pb_trip = pg_on & ~chk_done & pin_s.pgi_n
    & (tmr == TD4);
  wire sense_done = adc_done_i & ~frz & (adc_chan_o == 2'd0);
  wire fs_hit = sense_done & (state != HSF_ON)
    & (adc_data_i >= SHORT_CODE);

  // undervoltage needs both pins across their levels to change
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      uv_p <= 1'b0;
      oc_p <= 1'b0;
      pb_p <= 1'b0;
      fs_p <= 1'b0;
    end else begin
      if (~pin_s.uvl_ok & ~pin_s.uvh_ok) begin
        uv_p <= 1'b1;
      end else if (pin_s.uvl_ok & pin_s.uvh_ok) begin
        uv_p <= 1'b0;
      end
      // trip sets present, gate off clears it
      oc_p <= oc_trip | (oc_p & (state == HSF_ON));
      pb_p <= pb_trip | (pb_p & (state == HSF_ON));
      if (sense_done) begin
        fs_p <= fs_hit;
      end
    end
  end

  // ****************************************
  // fault register
  // ****************************************
  // events set, level conditions keep setting while present
  wire [7:0] fset = {~pin_s.ext_fault_n, gpi_p, fs_hit, ins_chg,
    pb_trip, oc_trip, (uv_p & ~uvl_rst) | (uvl_ret & ~pin_s.uvh_ok),
    ov_p};
  // bits that may not be cleared while the condition lasts
  wire [7:0] pres = {1'b0, gpi_p, fs_p, 1'b0, pb_p, oc_p, uv_p, ov_p};
  wire [7:0] f_wr = wr_fault ? (fault & (wd | pres)) : fault;
  wire [7:0] f_all = (on_fall | host_fall) ? (f_wr & pres) : f_wr;
  wire [7:0] f_ins = ins_fall ? (f_all & (pres | 8'h10)) : f_all;
  wire [7:0] f_uvl = uvl_rst ? 8'h00 : f_ins;
  wire [7:0] next_fault = f_uvl | fset;

  // set wins over every clear
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault <= `HSF_FAULT_RST;
    end else begin
      fault <= next_fault;
    end
  end

  // ****************************************
  // alert and control registers
  // ****************************************
  // a fault already reported stays quiet until it clears
  wire [7:0] pend = fault & alert_en & ~acked;
  wire rel = ara_release_i | addressed_i;
  wire [7:0] next_acked = rel ? ((acked | alert_en) & next_fault)
    : (acked & next_fault);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      alert_en <= `HSF_ALERT_RST;
      acked <= 8'h00;
      alert_q <= 1'b0;
    end else begin
      if (wr_alert) begin
        alert_en <= wd;
      end
      acked <= next_acked;
      alert_q <= |(next_fault & alert_en & ~next_acked);
    end
  end

  // host_on follows pin edges; a pin edge beats a write
  logic next_host;
  always_comb begin
    next_host = ctrl[`HSF_C_HOST];
    if (wr_ctrl) begin
      next_host = wd[`HSF_C_HOST];
    end
    if (on_rise) begin
      next_host = 1'b1;
    end else if (on_fall) begin
      next_host = 1'b0;
    end
  end

  // host_on resets off so serial-only boards start with gate low
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl <= `HSF_CTRL_RST;
      host_d <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wd;
      end
      ctrl[`HSF_C_HOST] <= next_host;
      host_d <= ctrl[`HSF_C_HOST];
    end
  end

  // ****************************************
  // gate policy
  // ****************************************
  // retry bits choose the present bit, else the fault bit
  wire blk_ov = ov_p | (~ctrl[`HSF_C_OVRT] & fault[`HSF_F_OV]);
  wire blk_uv = uv_p | (~ctrl[`HSF_C_UVRT] & fault[`HSF_F_UV]);
  wire blk_oc = oc_p | (~ctrl[`HSF_C_OCRT] & fault[`HSF_F_OC]);
  wire blk_pb = pb_p | (~ctrl[`HSF_C_PBRT] & fault[`HSF_F_PB]);
  wire hold = blk_ov | blk_uv | blk_oc | blk_pb;
  wire on_req = ctrl[`HSF_C_HOST] & ~pin_s.ins_det_n;
  wire ov_wr_clr = wr_fault & fault[`HSF_F_OV] & ~wd[`HSF_F_OV]
    & ~ov_p;
  wire ov_drop = ~pin_s.ov_trip & pin_d.ov_trip & ctrl[`HSF_C_OVRT];
  // cooling after a breaker trip cannot be shortened
  wire [23:0] load = oc_cool ? TD4 : TD1;
  wire wait_done = (tmr == 24'h00_0000) | (ov_skip & ~oc_cool);

  // ov_skip follows the last cause that held the gate off; oc_cool holds until the gate is on
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ov_skip <= 1'b0;
      oc_cool <= 1'b0;
    end else begin
      if (oc_trip) begin
        oc_cool <= 1'b1;
      end else if (state == HSF_ON) begin
        oc_cool <= 1'b0;
      end
      if (ov_wr_clr | ov_drop) begin
        ov_skip <= 1'b1;
      end else if ((state == HSF_ON) | blk_uv | blk_pb | blk_oc) begin
        ov_skip <= 1'b0;
      end
    end
  end

  // off, wait a delay period, on with power-bad check
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= HSF_OFF;
      tmr <= 24'h00_0000;
      chk_done <= 1'b0;
    end else begin
      case (state)
        HSF_OFF: begin
          chk_done <= 1'b0;
          tmr <= load;
          if (on_req & ~hold) begin
            state <= HSF_WAIT;
          end
        end
        HSF_WAIT: begin
          if (~on_req | hold) begin
            state <= HSF_OFF;
          end else if (wait_done) begin
            state <= HSF_ON;
            tmr <= 24'h00_0000;
          end else begin
            tmr <= tmr - 24'h00_0001;
          end
        end
        HSF_ON: begin
          if (~on_req | hold | oc_trip | pb_trip) begin
            state <= HSF_OFF;
          end else if (pg_on & ~chk_done) begin
            if (~pin_s.pgi_n) begin
              chk_done <= 1'b1;
            end
            tmr <= tmr + 24'h00_0001;
          end
        end
        default: begin
          state <= HSF_OFF;
        end
      endcase
    end
  end

  // breaker timer runs while the current limit is engaged
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cbt <= 24'h00_0000;
    end else if ((state == HSF_ON) & pin_s.oc_limit & ~oc_trip) begin
      cbt <= cbt + 24'h00_0001;
    end else begin
      cbt <= 24'h00_0000;
    end
  end

  // ****************************************
  // converter sequencing and results
  // ****************************************
  // start pulse every third of the refresh period
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      adt <= 24'h00_0000;
      adc_start_o <= 1'b0;
      adc_chan_o <= 2'd0;
    end else begin
      adc_start_o <= (adt == AD1) & ~frz;
      adt <= (adt == AD1) ? 24'h00_0000 : adt + 24'h00_0001;
      if (adc_done_i & ~frz) begin
        adc_chan_o <= (adc_chan_o == 2'd2) ? 2'd0
          : adc_chan_o + 2'd1;
      end
    end
  end

  // result pair: upper eight bits, then two bits left aligned
  wire [2:0] pair = {adc_chan_o, 1'b0};
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 6; i++) begin
        adc_q[i] <= 8'h00;
      end
    end else if (wr_adc) begin
      adc_q[adc_i] <= wd;
    end else if (adc_done_i & ~frz & (adc_chan_o != 2'd3)) begin
      adc_q[pair] <= adc_data_i[9:2];
      adc_q[3'(pair + 3'd1)] <= {adc_data_i[1:0], 6'h00};
    end
  end

  // ****************************************
  // pins out
  // ****************************************
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pg_q <= 1'b0;
    end else begin
      pg_q <= pg_on & ~pb_trip & ~oc_trip;
    end
  end

  // dual pin is open drain: low level only, enable picks mode
  wire [1:0] cfg = ctrl[7:6];
  assign dual_purpose_power_good_pin_o = 1'b0;
  assign dual_purpose_power_good_pin_oe_o = (cfg == 2'b00) ? pg_q :
    (cfg == 2'b01) ? ~pg_q :
    (cfg == 2'b10) ? ~alert_en[`HSF_F_GPI] : 1'b0;
  assign power_good_output_n_o = ~pg_q;
  assign gate_on_o = (state == HSF_ON);
  assign alert_n_o = 1'b0;
  assign alert_oe_o = alert_q;

endmodule : hsf_core
`default_nettype wire

// [design/hsf_defs.svh]
// Purpose: offsets, field positions, reset values and timing figures of the hot-swap fault logic
// Assumes: 32-bit Avalon-MM words, one register per aligned word
// Notes: counts in cycles are derived from these figures inside the core
`ifndef HSF_DEFS_SVH
`define HSF_DEFS_SVH
// register indexes, byte address is four times the index
`define HSF_IDX_STATUS 4'h0
`define HSF_IDX_FAULT 4'h1
`define HSF_IDX_ALERT 4'h2
`define HSF_IDX_CTRL 4'h3
`define HSF_IDX_ADC0 4'h4
`define HSF_IDX_ADC5 4'h9
// fault and status bit positions
`define HSF_F_OV 0
`define HSF_F_UV 1
`define HSF_F_OC 2
`define HSF_F_PB 3
`define HSF_F_INS 4
`define HSF_F_FS 5
`define HSF_F_GPI 6
`define HSF_F_EXT 7
// control bit positions
`define HSF_C_OVRT 0
`define HSF_C_UVRT 1
`define HSF_C_OCRT 2
`define HSF_C_HOST 3
`define HSF_C_PBRT 4
`define HSF_C_FRZ 5
`define HSF_C_CFG 6
// reset values
`define HSF_CTRL_RST 8'h03
`define HSF_ALERT_RST 8'h00
`define HSF_FAULT_RST 8'h00
// idle pin levels: supplies good, check input and external fault high
`define HSF_PIN_IDLE 11'h1c6
// timing and converter figures
`define HSF_CLK_HZ 20000000
`define HSF_TD_MS 50
`define HSF_CB_US 530
`define HSF_ADC_DHZ 73
`define HSF_SHORT_UV 2000
`define HSF_SENSE_LSB_NV 62500
`endif

// [design/hsf_pkg.sv]
// Purpose: types shared by the hot-swap fault logic
// Assumes: comparators outside turn analog levels into logic levels
// Notes: field order of the pin bundle is fixed for the bench
package hsf_pkg;
  // gate controller states
  typedef enum logic [1:0] {
    HSF_OFF,
    HSF_WAIT,
    HSF_ON
  } hsf_gate_t;

  // comparator and pin levels arriving from outside the clock domain
  typedef struct packed {
    logic on_pin;
    logic ins_det_n;
    logic uvl_above_rst;
    logic uvl_ok;
    logic uvh_ok;
    logic ov_trip;
    logic oc_limit;
    logic pg_ready;
    logic pgi_n;
    logic ext_fault_n;
    logic dual_purpose_power_good_pin_in;
  } hsf_pins_t;
endpackage : hsf_pkg

// [verification/hsf_core_chk.sv]
// Purpose: port assertions for the hot-swap fault core
// Assumes: one clock domain, reset active high
// Notes: the power-bad bound follows TD_CYC handed on by the bind
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checker
// ****************
module hsf_core_chk
  import hsf_pkg::*;
#(
  parameter int TD_CYC = 20
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire hsf_pins_t pins_i,
  input wire logic [1:0] adc_chan_o,
  input wire logic adc_start_o,
  input wire logic ara_release_i,
  input wire logic addressed_i,
  input wire logic gate_on_o,
  input wire logic power_good_output_n_o,
  input wire logic alert_n_o,
  input wire logic alert_oe_o
);
  localparam int PB_MAX = 4 * TD_CYC + 4;
  int pb_cnt;
  logic pgi_seen;
  logic wrote;
  // age of power good; a low check input lifts the bound, since the gate may then stay on
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pb_cnt <= 0;
      pgi_seen <= 1'b0;
      wrote <= 1'b0;
    end else begin
      pb_cnt <= power_good_output_n_o ? 0 : pb_cnt + 1;
      pgi_seen <= !power_good_output_n_o && (pgi_seen || !pins_i.pgi_n);
      wrote <= wrote || (avs_write_i && !avs_waitrequest_o);
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  // bus, reset and converter
  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held past one cycle");
  reset_idle_a: assert property ($fell(reset_i) |-> !gate_on_o && !alert_oe_o && power_good_output_n_o)
    else $error("outputs not idle after reset");
  adc_pulse_a: assert property (adc_start_o |=> !adc_start_o [*8])
    else $error("converter start not a spaced pulse");
  adc_order_a: assert property ($changed(adc_chan_o) |->
    adc_chan_o == (($past(adc_chan_o) == 2'h2) ? 2'h0 : $past(adc_chan_o) + 2'h1))
    else $error("converter channel order broken");
  // power good and its check timer
  pg_on_a: assert property ($fell(power_good_output_n_o) |-> gate_on_o)
    else $error("power good without gate on");
  pb_limit_a: assert property (!power_good_output_n_o && !pgi_seen |-> pb_cnt < PB_MAX)
    else $error("power bad trip missed");
  // alert line
  alert_en_a: assert property (!wrote |-> !alert_oe_o)
    else $error("alert before any enable written");
  alert_pin_a: assert property (alert_oe_o |-> !alert_n_o)
    else $error("alert line driven high");
  alert_rel_a: assert property ((ara_release_i || addressed_i) && alert_oe_o |=> !alert_oe_o)
    else $error("alert not released");
  cover property ($rose(alert_oe_o));
  cover property ($fell(alert_oe_o));
  cover property ($rose(gate_on_o));
  cover property ($fell(power_good_output_n_o));
endmodule : hsf_core_chk
bind hsf_core hsf_core_chk #(.TD_CYC(TD_CYC)) u_hsf_core_chk (.*);
`default_nettype wire

// [verification/hsf_host_model.sv]
// Purpose: far side of the fault core: converter and alert-responding host
// Assumes: converter result valid while done is high
// Notes: link clock runs only inside an alert-response frame
`timescale 1ns/1ps
`default_nettype none
// ****************
// host and converter model
// ****************
module hsf_host_model (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic alert_oe_i,
  input wire logic adc_start_i,
  input wire logic [1:0] adc_chan_i,
  input wire logic [9:0] sense_i,
  input wire logic [9:0] aux_i,
  input wire logic respond_i,
  output logic [9:0] adc_data_o,
  output var logic adc_done_o,
  output var logic ara_release_o,
  output var logic link_clk_o
);
  logic idle_tog;
  // converter answers one cycle after start
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      adc_done_o <= 1'b0;
      idle_tog <= 1'b0;
    end else begin
      adc_done_o <= adc_start_i;
      idle_tog <= ~idle_tog;
    end
  end
  // outside a result the data bus toggles, so stale values cannot pass
  assign adc_data_o = !adc_done_o ? {5{idle_tog, ~idle_tog}} : (adc_chan_i == 2'h0) ? sense_i : aux_i;
  initial begin
    link_clk_o = 1'b1;
    ara_release_o = 1'b0;
  end
  // response frame: nine address bits, then the won arbitration is reported
  always begin
    @(posedge sys_clk_i);
    if (alert_oe_i && respond_i && !reset_i) begin
      repeat (9) begin
        #200 link_clk_o = 1'b0;
        #200 link_clk_o = 1'b1;
      end
      @(posedge sys_clk_i);
      ara_release_o <= 1'b1;
      @(posedge sys_clk_i);
      ara_release_o <= 1'b0;
    end
  end
endmodule : hsf_host_model
`default_nettype wire

// [verification/testbench.sv]
// Purpose: self-checking bench of the hot-swap fault core
// Assumes: short timers; register reads judged through a queue
// Notes: pins change right after a rising edge
`timescale 1ns/1ps
`default_nettype none
`include "hsf_defs.svh"
// ****************
// bench top
// ****************
module testbench
  import hsf_pkg::*;
();
  localparam int TD = 20;
  logic sys_clk_i, reset_i, avs_read_i, avs_write_i, adc_done_i, ara_release_i, addressed_i, respond;
  logic avs_waitrequest_o, gate_on_o, power_good_output_n_o, dual_purpose_power_good_pin_o, dual_purpose_power_good_pin_oe_o, alert_n_o, alert_oe_o;
  logic adc_start_o;
  logic [5:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [9:0] adc_data_i, sense, aux;
  logic [1:0] adc_chan_o;
  hsf_pins_t pins_i;
  logic [7:0] exp_q[$];
  logic [15:0] rnd = 16'h9c8f;
  int n_errors = 0;
  int n_compared = 0;
  hsf_core #(.TD_CYC(TD), .CB_CYC(10), .ADC_CYC(30)) u_hsf_core (.*);
  hsf_host_model u_hsf_host_model (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .alert_oe_i(alert_oe_o),
    .adc_start_i(adc_start_o), .adc_chan_i(adc_chan_o), .sense_i(sense), .aux_i(aux), .respond_i(respond),
    .adc_data_o(adc_data_i), .adc_done_o(adc_done_i), .ara_release_o(ara_release_i), .link_clk_o());
  always #25 sys_clk_i = ~sys_clk_i;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic check_reg(input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR readdata expected %h seen %h", e, s);
    end
  endtask : check_reg
  // sampled mid-cycle where the output has settled
  task automatic check_pin(input logic e);
    @(negedge sys_clk_i);
    n_compared++;
    if (alert_oe_o !== e) begin
      n_errors++;
      $display("ERROR alert_oe expected %b seen %b", e, alert_oe_o);
    end
    @(posedge sys_clk_i);
  endtask : check_pin
  task automatic check_dual_purpose_power_good_pin(input logic e);
    @(negedge sys_clk_i);
    n_compared++;
    if (dual_purpose_power_good_pin_oe_o !== e) begin
      n_errors++;
      $display("ERROR dual_purpose_power_good_pin_oe expected %b seen %b", e, dual_purpose_power_good_pin_oe_o);
    end
    @(posedge sys_clk_i);
  endtask : check_dual_purpose_power_good_pin
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : tick
  // one transfer; held until waitrequest is seen low, then released at that edge
  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    int n;
    n = 0;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= {i, 2'b00};
    avs_writedata_i <= {24'h0, d};
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      finish_test();
    end
    @(posedge sys_clk_i);
  endtask : bus
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, i, 8'h00);
  endtask : rd
  // read results are judged in the cycle they are taken
  always @(posedge sys_clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0)
      check_reg({24'h0, exp_q.pop_front()}, avs_readdata_o);
  end
  initial begin
    {sys_clk_i, avs_read_i, avs_write_i, addressed_i, respond, avs_address_i} = '0;
    {avs_writedata_i, sense, aux} = '0;
    reset_i = 1'b1;
    pins_i = 11'h1ce; // supplies good, on pin low, power good ready, check input high
    tick(12);
    reset_i <= 1'b0;
    tick(2);
    bus(1'b1, `HSF_IDX_FAULT, 8'h00);
    rd(`HSF_IDX_FAULT, 8'h00);
    rd(`HSF_IDX_CTRL, `HSF_CTRL_RST);
    rd(`HSF_IDX_ALERT, 8'h00);
    check_dual_purpose_power_good_pin(1'b0);
    rnd = lfsr(rnd);
    sense <= rnd[9:0] | 10'h020;
    rnd = lfsr(rnd);
    aux <= rnd[9:0];
    tick(150);
    rd(`HSF_IDX_STATUS, 8'h20);
    rd(`HSF_IDX_FAULT, 8'h20);
    rd(4'h4, sense[9:2]);
    rd(4'h5, {sense[1:0], 6'h00});
    rd(4'h6, aux[9:2]);
    rd(4'h8, aux[9:2]);
    bus(1'b1, `HSF_IDX_FAULT, 8'h00);
    rd(`HSF_IDX_FAULT, 8'h20);
    sense <= 10'h01f;
    tick(150);
    bus(1'b1, `HSF_IDX_FAULT, 8'h00);
    rd(`HSF_IDX_FAULT, 8'h00);
    bus(1'b1, `HSF_IDX_CTRL, 8'h23);
    bus(1'b1, 4'h4, 8'h5a);
    tick(100);
    rd(4'h4, 8'h5a);
    bus(1'b1, 4'ha, 8'hff);
    rd(4'ha, 8'h00);
    bus(1'b1, `HSF_IDX_CTRL, 8'h03);
    pins_i.ext_fault_n <= 1'b0;
    bus(1'b1, `HSF_IDX_ALERT, 8'h80);
    tick(5);
    check_pin(1'b1);
    respond <= 1'b1;
    tick(120);
    check_pin(1'b0);
    respond <= 1'b0;
    tick(40);
    check_pin(1'b0);
    pins_i.ext_fault_n <= 1'b1;
    tick(4);
    bus(1'b1, `HSF_IDX_FAULT, 8'h00);
    pins_i.ext_fault_n <= 1'b0;
    tick(6);
    check_pin(1'b1);
    addressed_i <= 1'b1;
    tick(1);
    addressed_i <= 1'b0;
    tick(2);
    check_pin(1'b0);
    pins_i.ext_fault_n <= 1'b1;
    tick(4);
    bus(1'b1, `HSF_IDX_FAULT, 8'h00);
    bus(1'b1, `HSF_IDX_CTRL, 8'h0b);
    tick(TD + 10);
    rd(`HSF_IDX_STATUS, 8'h80);
    tick(4 * TD + 20);
    rd(`HSF_IDX_STATUS, 8'h00);
    rd(`HSF_IDX_FAULT, 8'h08);
    pins_i.pgi_n <= 1'b0;
    tick(3 * TD);
    rd(`HSF_IDX_STATUS, 8'h00);
    bus(1'b1, `HSF_IDX_FAULT, 8'h00);
    tick(TD + 10);
    rd(`HSF_IDX_STATUS, 8'h80);
    tick(4 * TD + 10);
    rd(`HSF_IDX_STATUS, 8'h80);
    check_dual_purpose_power_good_pin(1'b1);
    pins_i.ext_fault_n <= 1'b0;
    tick(5);
    pins_i.ext_fault_n <= 1'b1;
    bus(1'b1, `HSF_IDX_CTRL, 8'h03);
    rd(`HSF_IDX_FAULT, 8'h00);
    pins_i.ins_det_n <= 1'b1;
    pins_i.ext_fault_n <= 1'b0;
    tick(6);
    pins_i.ext_fault_n <= 1'b1;
    rd(`HSF_IDX_STATUS, 8'h10);
    pins_i.ins_det_n <= 1'b0;
    tick(6);
    rd(`HSF_IDX_FAULT, 8'h10);
    {pins_i.uvl_above_rst, pins_i.uvl_ok, pins_i.uvh_ok} <= 3'h0;
    tick(6);
    pins_i.uvl_above_rst <= 1'b1;
    tick(6);
    rd(`HSF_IDX_FAULT, 8'h02);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
